// ==== logic/pfs_top.sv ====
// pin function select for port 8 bits 2..0 and port 7 bit 7
// What this block does
// - port8_bit2 input: interrupt zero request comes only from pin edges, never writes.
// - direction 0 input, pull-up selects pulled high; direction 1 drives output.
// - timer input pins count source; gate or trigger only with mode bit 4.
// - port8_bit0 gives timer 4 up/down polarity when two-phase select is 0, timer 4 mode bit 4 is set and bit 2 is clear.
// - port8_bit0 gives timer 4 two-phase pulse input when two-phase select is 1, timer 4 mode bit 4 is set and bit 2 is clear.
// - timer 4 mode bit 2 makes port8_bit0 drive the timer 4 pulse output while two-phase select is 0.
//
// The Wishbone register port was chosen for this implementation.
module pfs_top
	import pfs_pkg::*;
(
	input wire logic clk_i, // system clock, 20 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic [pfs_pkg::AW-1:0] wb_adr_i, // wishbone byte address
	input wire logic [31:0] wb_dat_i, // wishbone write data
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic wb_we_i, // wishbone write enable
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic [3:0] pin_i, // pin levels: p80, p81, p82, p77
	output logic [3:0] pin_o, // pin drive levels
	output logic [3:0] pin_oe_o, // pin output enables, high while driving
	output logic [3:0] pin_pu_o, // pull-up enables
	input wire logic [3:0] port_out_i, // port data latch values for the same pins
	input wire logic timer4_pulse_i, // timer 4 pulse output from the timer
	input wire logic phase_u_i, // U phase waveform
	input wire logic phase_u_n_i, // inverted U phase waveform
	output logic ext_irq_zero_req_o, // interrupt zero edge request, one cycle
	output logic ext_irq_zero_pin_o, // interrupt zero pin level
	output logic timer4_input_pin_o, // timer 4 count source input
	output logic timer4_gate_o, // timer 4 gate or trigger input
	output logic timer4_updown_o, // timer 4 up/down polarity input
	output logic timer4_two_phase_o, // timer 4 two-phase pulse input
	output logic timer3_input_pin_o, // timer 3 count source input
	output logic timer3_gate_o // timer 3 gate or trigger input
);
	import pfs_pkg::*;

	localparam int PIN_P80 = 0;
	localparam int PIN_P81 = 1;
	localparam int PIN_P82 = 2;
	localparam int PIN_P77 = 3;

	// bus handshake state
	pfs_bus_t bus_reg, bus_next;
	logic ack_reg, ack_next;
	logic rd_pend_reg, rd_pend_next;
	logic [31:0] dat_reg, dat_next;

	// pin output state
	logic [3:0] pin_reg, pin_next;
	logic [3:0] oe_reg, oe_next;
	logic [3:0] pu_reg, pu_next;
	logic irq_req_reg, irq_req_next;
	logic irq_lvl_reg, irq_lvl_next;
	logic irq_prev_reg, irq_prev_next;
	logic t4_in_reg, t4_in_next;
	logic t4_gate_reg, t4_gate_next;
	logic t4_ud_reg, t4_ud_next;
	logic t4_tp_reg, t4_tp_next;
	logic t3_in_reg, t3_in_next;
	logic t3_gate_reg, t3_gate_next;

	logic [3:0] idx;
	logic hit;
	logic mem_we;
	logic [7:0] rdata;
	logic [7:0] status;
	logic [7:0] r_3ph, r_trig, r_ud, r_t3, r_t4, r_d7, r_d8, r_pu7, r_pu8;

	// map a byte address to a register index; hit is low for unmapped
	function automatic logic [4:0] addr_decode(input logic [AW-1:0] a);
		unique case (a)
			OFS_THREE_PHASE: addr_decode = {1'b1, IX_THREE_PHASE};
			OFS_TRIG_SEL: addr_decode = {1'b1, IX_TRIG_SEL};
			OFS_UPDOWN: addr_decode = {1'b1, IX_UPDOWN};
			OFS_T3_MODE: addr_decode = {1'b1, IX_T3_MODE};
			OFS_T4_MODE: addr_decode = {1'b1, IX_T4_MODE};
			OFS_P7_DIR: addr_decode = {1'b1, IX_P7_DIR};
			OFS_P8_DIR: addr_decode = {1'b1, IX_P8_DIR};
			OFS_PU_P7: addr_decode = {1'b1, IX_PU_P7};
			OFS_PU_P8: addr_decode = {1'b1, IX_PU_P8};
			OFS_PIN_STATUS: addr_decode = {1'b1, IX_STATUS};
			default: addr_decode = 5'h00;
		endcase
	endfunction

	// timer input pin is used when its direction is input and trigger bits are 0
	function automatic logic timer_in_sel(input logic dir, input logic trg_hi,
			input logic trg_lo);
		timer_in_sel = !dir && !trg_hi && !trg_lo;
	endfunction

	// pull-up acts only on a pin whose direction is input; a driven pin never pulls
	function automatic logic pullup_sel(input logic dir, input logic pu);
		pullup_sel = !dir && pu;
	endfunction

	assign {hit, idx} = addr_decode(wb_adr_i);
	// byte lane 0 carries the 8-bit register data
	assign mem_we = (bus_reg == PFS_IDLE) && wb_cyc_i && wb_stb_i && wb_we_i && hit
		&& wb_sel_i[0];
	assign status = {4'h0, pin_i};

	pfs_regmem u_regmem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.we_i(mem_we),
		.idx_i(idx),
		.wdata_i(wb_dat_i[7:0]),
		.status_i(status),
		.rdata_o(rdata),
		.three_phase_o(r_3ph),
		.trig_sel_o(r_trig),
		.updown_o(r_ud),
		.t3_mode_o(r_t3),
		.t4_mode_o(r_t4),
		.p7_dir_o(r_d7),
		.p8_dir_o(r_d8),
		.pu_p7_o(r_pu7),
		.pu_p8_o(r_pu8)
	);

	// wishbone slave: memory read data appear one cycle after the request
	always_comb begin
		bus_next = bus_reg;
		ack_next = 1'b0;
		rd_pend_next = 1'b0;
		dat_next = dat_reg;
		unique case (bus_reg)
			PFS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					bus_next = PFS_ACK;
					rd_pend_next = hit;
				end
			end
			PFS_ACK: begin
				if (!ack_reg) begin
					// a master that drops its strobe before the answer gets none
					if (wb_cyc_i && wb_stb_i) begin
						ack_next = 1'b1;
						dat_next = rd_pend_reg ? {24'h000000, rdata} : 32'h00000000;
					end else begin
						bus_next = PFS_IDLE;
					end
				end else begin
					bus_next = PFS_IDLE;
				end
			end
		endcase
	end

	// bus registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_reg <= PFS_IDLE;
			ack_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else if (ce_i) begin
			bus_reg <= bus_next;
			ack_reg <= ack_next;
			rd_pend_reg <= rd_pend_next;
			dat_reg <= dat_next;
		end
	end

	// register fields that steer the four pins
	logic f_u_mode; // three phase outputs own bits 0 and 1
	logic f_two_phase; // timer 4 two-phase pulse processing
	logic f_t4_gate; // timer 4 gate or trigger mode bit
	logic f_t4_pulse; // timer 4 pulse output mode bit
	logic f_t3_gate; // timer 3 gate or trigger mode bit
	logic f_dir_p80; // port8_bit0 direction
	logic f_dir_p81; // port8_bit1 direction
	logic f_dir_p82; // port8_bit2 direction
	logic f_dir_p77; // port7_bit7 direction
	logic f_pu_p8; // pull-up of the port 8 group
	logic f_pu_p7; // pull-up of the port 7 group
	logic f_t4_sel; // timer 4 input pin selected
	logic f_t3_sel; // timer 3 input pin selected

	// field extraction, shared by every pin function below
	assign f_u_mode = r_3ph[B_THREE_PHASE];
	assign f_two_phase = r_ud[B_T4_TWO_PHASE];
	assign f_t4_gate = r_t4[B_MODE_GATE];
	assign f_t4_pulse = r_t4[B_MODE_PULSE];
	assign f_t3_gate = r_t3[B_MODE_GATE];
	assign f_dir_p80 = r_d8[B_P8_B0];
	assign f_dir_p81 = r_d8[B_P8_B1];
	assign f_dir_p82 = r_d8[B_P8_B2];
	assign f_dir_p77 = r_d7[B_P7_B7];
	assign f_pu_p8 = r_pu8[B_PU_P80_83];
	assign f_pu_p7 = r_pu7[B_PU_P74_77];
	assign f_t4_sel = timer_in_sel(f_dir_p81, r_trig[B_T4_TRIG_HI], r_trig[B_T4_TRIG_LO]);
	assign f_t3_sel = timer_in_sel(f_dir_p77, r_trig[B_T3_TRIG_HI], r_trig[B_T3_TRIG_LO]);

	// pin function selection
	always_comb begin
		logic t4_pulse;
		logic t4_in_dir;
		// pulse output is lost while two-phase processing is selected
		t4_pulse = f_t4_pulse && !f_two_phase;
		// port8_bit0 feeds timer 4 only as an input in event mode
		t4_in_dir = !f_dir_p80 && f_t4_gate && !f_t4_pulse;

		// ordinary port behaviour first
		pin_next = port_out_i;
		oe_next[PIN_P80] = f_dir_p80;
		oe_next[PIN_P81] = f_dir_p81;
		oe_next[PIN_P82] = f_dir_p82;
		oe_next[PIN_P77] = f_dir_p77;
		pu_next[PIN_P80] = pullup_sel(f_dir_p80, f_pu_p8);
		pu_next[PIN_P81] = pullup_sel(f_dir_p81, f_pu_p8);
		pu_next[PIN_P82] = pullup_sel(f_dir_p82, f_pu_p8);
		pu_next[PIN_P77] = pullup_sel(f_dir_p77, f_pu_p7);

		// timer 4 pulse output takes port8_bit0 whatever its direction
		if (t4_pulse) begin
			pin_next[PIN_P80] = timer4_pulse_i;
			oe_next[PIN_P80] = 1'b1;
			pu_next[PIN_P80] = 1'b0;
		end
		// three phase outputs override everything on bits 0 and 1
		if (f_u_mode) begin
			pin_next[PIN_P80] = phase_u_i;
			pin_next[PIN_P81] = phase_u_n_i;
			oe_next[PIN_P80] = 1'b1;
			oe_next[PIN_P81] = 1'b1;
			pu_next[PIN_P80] = 1'b0;
			pu_next[PIN_P81] = 1'b0;
		end
		// interrupt zero follows the pin while it is an input
		irq_lvl_next = f_dir_p82 ? irq_lvl_reg : pin_i[PIN_P82];
		irq_prev_next = irq_lvl_reg;
		// only a level change makes a request, so register writes cannot
		irq_req_next = !f_dir_p82 && (irq_lvl_reg != irq_prev_reg);

		// timer inputs; three phase mode takes bits 0 and 1 away from timer 4
		t4_in_next = !f_u_mode && f_t4_sel && pin_i[PIN_P81];
		t4_gate_next = !f_u_mode && f_t4_sel && f_t4_gate && pin_i[PIN_P81];
		t3_in_next = f_t3_sel && pin_i[PIN_P77];
		t3_gate_next = f_t3_sel && f_t3_gate && pin_i[PIN_P77];

		// port8_bit0 as up/down polarity or two-phase pulse input
		t4_ud_next = !f_u_mode && t4_in_dir && !f_two_phase && pin_i[PIN_P80];
		t4_tp_next = !f_u_mode && t4_in_dir && f_two_phase && pin_i[PIN_P80];
	end

	// pin and timer side registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_reg <= 4'h0;
			oe_reg <= 4'h0;
			pu_reg <= 4'h0;
			irq_req_reg <= 1'b0;
			irq_lvl_reg <= 1'b0;
			irq_prev_reg <= 1'b0;
			t4_in_reg <= 1'b0;
			t4_gate_reg <= 1'b0;
			t4_ud_reg <= 1'b0;
			t4_tp_reg <= 1'b0;
			t3_in_reg <= 1'b0;
			t3_gate_reg <= 1'b0;
		end else if (ce_i) begin
			pin_reg <= pin_next;
			oe_reg <= oe_next;
			pu_reg <= pu_next;
			irq_req_reg <= irq_req_next;
			irq_lvl_reg <= irq_lvl_next;
			irq_prev_reg <= irq_prev_next;
			t4_in_reg <= t4_in_next;
			t4_gate_reg <= t4_gate_next;
			t4_ud_reg <= t4_ud_next;
			t4_tp_reg <= t4_tp_next;
			t3_in_reg <= t3_in_next;
			t3_gate_reg <= t3_gate_next;
		end
	end

	// outputs straight from flip-flops
	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign pin_o = pin_reg;
	assign pin_oe_o = oe_reg;
	assign pin_pu_o = pu_reg;
	assign ext_irq_zero_req_o = irq_req_reg;
	assign ext_irq_zero_pin_o = irq_lvl_reg;
	assign timer4_input_pin_o = t4_in_reg;
	assign timer4_gate_o = t4_gate_reg;
	assign timer4_updown_o = t4_ud_reg;
	assign timer4_two_phase_o = t4_tp_reg;
	assign timer3_input_pin_o = t3_in_reg;
	assign timer3_gate_o = t3_gate_reg;
endmodule

// ==== logic/pfs_pkg.sv ====
// constants for the port 8 / port 7 pin function select block
package pfs_pkg;
	localparam int AW = 12;
	localparam logic [11:0] OFS_THREE_PHASE = 12'h348;
	localparam logic [11:0] OFS_TRIG_SEL = 12'h383;
	localparam logic [11:0] OFS_UPDOWN = 12'h384;
	localparam logic [11:0] OFS_T3_MODE = 12'h399;
	localparam logic [11:0] OFS_T4_MODE = 12'h39a;
	localparam logic [11:0] OFS_P7_DIR = 12'h3ef;
	localparam logic [11:0] OFS_P8_DIR = 12'h3f2;
	localparam logic [11:0] OFS_PU_P7 = 12'h3fd;
	localparam logic [11:0] OFS_PU_P8 = 12'h3fe;
	localparam logic [11:0] OFS_PIN_STATUS = 12'h400;
	localparam logic [1:0] REG_NONE = 2'h0;
	// number of mapped registers and index width
	localparam int NREG = 10;
	localparam int IW = 4;
	// field positions
	localparam int B_THREE_PHASE = 2;
	localparam int B_T4_TRIG_HI = 7;
	localparam int B_T4_TRIG_LO = 6;
	localparam int B_T3_TRIG_HI = 5;
	localparam int B_T3_TRIG_LO = 4;
	localparam int B_T4_TWO_PHASE = 7;
	localparam int B_MODE_GATE = 4;
	localparam int B_MODE_PULSE = 2;
	localparam int B_P8_B0 = 0;
	localparam int B_P8_B1 = 1;
	localparam int B_P8_B2 = 2;
	localparam int B_P7_B7 = 7;
	localparam int B_PU_P80_83 = 0;
	localparam int B_PU_P74_77 = 7;
	localparam logic [7:0] RST_REG = 8'h00;
	// register index codes inside the small register memory
	localparam logic [3:0] IX_THREE_PHASE = 4'h0;
	localparam logic [3:0] IX_TRIG_SEL = 4'h1;
	localparam logic [3:0] IX_UPDOWN = 4'h2;
	localparam logic [3:0] IX_T3_MODE = 4'h3;
	localparam logic [3:0] IX_T4_MODE = 4'h4;
	localparam logic [3:0] IX_P7_DIR = 4'h5;
	localparam logic [3:0] IX_P8_DIR = 4'h6;
	localparam logic [3:0] IX_PU_P7 = 4'h7;
	localparam logic [3:0] IX_PU_P8 = 4'h8;
	localparam logic [3:0] IX_STATUS = 4'h9;
	// bus state
	typedef enum logic [1:0] {PFS_IDLE, PFS_ACK} pfs_bus_t;
endpackage

// ==== logic/pfs_regmem.sv ====
// register storage for the pin function select block, read data registered
module pfs_regmem
	import pfs_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable
	input wire logic we_i, // write strobe
	input wire logic [3:0] idx_i, // register index
	input wire logic [7:0] wdata_i, // write data
	input wire logic [7:0] status_i, // live pin status for the status index
	output logic [7:0] rdata_o, // registered read data
	output logic [7:0] three_phase_o, // three phase control
	output logic [7:0] trig_sel_o, // trigger select
	output logic [7:0] updown_o, // up/down flag
	output logic [7:0] t3_mode_o, // timer 3 mode
	output logic [7:0] t4_mode_o, // timer 4 mode
	output logic [7:0] p7_dir_o, // port 7 direction
	output logic [7:0] p8_dir_o, // port 8 direction
	output logic [7:0] pu_p7_o, // port 7 group pull-up
	output logic [7:0] pu_p8_o // port 8 group pull-up
);
	logic [7:0] mem_reg [0:NREG-2];
	logic [7:0] mem_next [0:NREG-2];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// next contents and read data
	always_comb begin
		for (int i = 0; i < NREG - 1; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (we_i && idx_i != IX_STATUS) begin
			mem_next[idx_i] = wdata_i;
		end
		rdata_next = (idx_i == IX_STATUS) ? status_i : mem_reg[idx_i];
	end

	// storage registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NREG - 1; i++) begin
				mem_reg[i] <= RST_REG;
			end
			rdata_reg <= RST_REG;
		end else if (ce_i) begin
			mem_reg <= mem_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign three_phase_o = mem_reg[IX_THREE_PHASE];
	assign trig_sel_o = mem_reg[IX_TRIG_SEL];
	assign updown_o = mem_reg[IX_UPDOWN];
	assign t3_mode_o = mem_reg[IX_T3_MODE];
	assign t4_mode_o = mem_reg[IX_T4_MODE];
	assign p7_dir_o = mem_reg[IX_P7_DIR];
	assign p8_dir_o = mem_reg[IX_P8_DIR];
	assign pu_p7_o = mem_reg[IX_PU_P7];
	assign pu_p8_o = mem_reg[IX_PU_P8];
endmodule

// ==== dv/pfs_pins.sv ====
// board circuitry on the four muxed pins
module pfs_pins (
	input wire logic clk_i, // system clock
	input wire logic [3:0] pin_o, // device drive level
	input wire logic [3:0] pin_oe_o, // device drives when high
	input wire logic [3:0] pin_pu_o, // device pull-up on
	input wire logic [3:0] ext_en_i, // board drives the pin
	input wire logic [3:0] ext_val_i, // board drive level
	output logic [3:0] lvl_o // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] last_reg = 4'h0;
	// device wins, then board, then pull-up; an open pin keeps changing
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lvl_o[i] = pin_oe_o[i] ? pin_o[i] : ext_en_i[i] ? ext_val_i[i] : pin_pu_o[i] | ~last_reg[i];
		end
	end
	// last level, so a floating pin never settles
	always_ff @(posedge clk_i) begin
		last_reg <= lvl_o;
	end
endmodule

// ==== dv/pfs_sva.sv ====
// checker for the pin function select block
module pfs_sva (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_ack_o, // ack
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic [3:0] pin_i, // pin levels
	input wire logic [3:0] pin_o, // drive levels
	input wire logic [3:0] pin_oe_o, // drive enables
	input wire logic [3:0] pin_pu_o, // pull-ups
	input wire logic [3:0] port_out_i, // port latch
	input wire logic ext_irq_zero_req_o, // irq pulse
	input wire logic ext_irq_zero_pin_o, // irq level
	input wire logic timer4_updown_o, // up/down input
	input wire logic timer4_two_phase_o, // two-phase input
	input wire logic timer3_input_pin_o, // count source
	input wire logic timer3_gate_o // gate input
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a new request waits two edges for its answer
	sequence s_wait;
		!wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o;
	endsequence
	property p_ack_lat;
		$rose(wb_cyc_i && wb_stb_i) |-> s_wait;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack latency wrong");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
	property p_dat_hold;
		!wb_ack_o |-> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
	property p_irq;
		ext_irq_zero_req_o |->
			$past(ext_irq_zero_pin_o) != $past(ext_irq_zero_pin_o, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq request without pin change");
	property p_out;
		pin_oe_o[3] && $past(pin_oe_o[3]) |-> pin_o[3] == $past(port_out_i[3]);
	endproperty
	a_out: assert property (p_out) else $error("output level not port latch");
	property p_pu;
		pin_pu_o[3] |-> !pin_oe_o[3];
	endproperty
	a_pu: assert property (p_pu) else $error("pull-up on a driven pin");
	property p_t3;
		timer3_gate_o |-> timer3_input_pin_o && $past(pin_i[3]);
	endproperty
	a_t3: assert property (p_t3) else $error("gate without count source");
	property p_t4ud;
		timer4_updown_o |-> $past(pin_i[0]) && !timer4_two_phase_o;
	endproperty
	a_t4ud: assert property (p_t4ud) else $error("up/down input wrong");
	property p_t4tp;
		timer4_two_phase_o |-> $past(pin_i[0]) && !timer4_updown_o;
	endproperty
	a_t4tp: assert property (p_t4tp) else $error("two-phase input wrong");
endmodule
bind pfs_top pfs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pin_i(pin_i),
	.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .port_out_i(port_out_i),
	.ext_irq_zero_req_o(ext_irq_zero_req_o), .ext_irq_zero_pin_o(ext_irq_zero_pin_o),
	.timer4_updown_o(timer4_updown_o), .timer4_two_phase_o(timer4_two_phase_o),
	.timer3_input_pin_o(timer3_input_pin_o), .timer3_gate_o(timer3_gate_o));

// ==== dv/pfs_top_bench.sv ====
// self-checking bench for the pin function select block
module pfs_top_bench
	import pfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] port_out_i = 4'h0;
	logic [3:0] ext_en = 4'h7;
	logic [3:0] ext_val = 4'h0;
	logic t4_pulse = 1'b0;
	logic ph_u = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, irq_req, irq_lvl, t4_in, t4_gate, t4_ud, t4_tp, t3_in, t3_gate;
	logic [3:0] pin_i, pin_o, pin_oe_o, pin_pu_o;
	logic [7:0] q;
	int fails = 0;
	int comparisons = 0;
	int reqs = 0;
	int n0;
	logic [11:0] ofs [9] = '{OFS_THREE_PHASE, OFS_TRIG_SEL, OFS_UPDOWN, OFS_T3_MODE,
		OFS_T4_MODE, OFS_P7_DIR, OFS_P8_DIR, OFS_PU_P7, OFS_PU_P8};
	pfs_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(4'hf), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .port_out_i(port_out_i),
		.timer4_pulse_i(t4_pulse), .phase_u_i(ph_u), .phase_u_n_i(~ph_u),
		.ext_irq_zero_req_o(irq_req), .ext_irq_zero_pin_o(irq_lvl),
		.timer4_input_pin_o(t4_in), .timer4_gate_o(t4_gate), .timer4_updown_o(t4_ud),
		.timer4_two_phase_o(t4_tp), .timer3_input_pin_o(t3_in), .timer3_gate_o(t3_gate));
	pfs_pins u_pins (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));
	// clock and request counter
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (irq_req === 1'b1) reqs++;
	end
	task conclude;
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// one classic cycle, held until ack is seen at a rising edge
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			fails++;
			conclude();
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input string s, input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(s, e, q);
	endtask
	task settle;
		repeat (4) @(posedge clk_i);
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ofs[i]) begin
			rd("reset", ofs[i], 8'h00);
			wr(ofs[i], 8'(8'h5a + i));
			rd("readback", ofs[i], 8'(8'h5a + i));
			wr(ofs[i], 8'h00);
		end
		wr(12'h500, 8'hff);
		rd("unmapped", 12'h500, 8'h00);
		// p77 pulled high with the board off, then driven
		wr(OFS_PU_P7, 8'h80);
		settle();
		chk("pullup", 8'h08, 8'(pin_pu_o));
		chk("enable", 8'h00, 8'(pin_oe_o));
		chk("t3 count", 8'h01, 8'(t3_in));
		port_out_i <= 4'h8;
		wr(OFS_P7_DIR, 8'h80);
		settle();
		chk("enable", 8'h08, 8'(pin_oe_o));
		chk("drive", 8'h08, 8'(pin_o));
		chk("t3 count", 8'h00, 8'(t3_in));
		wr(OFS_P7_DIR, 8'h00);
		ext_en <= 4'hf;
		ext_val <= 4'hf;
		// timer inputs: count, gate, up/down, then each trigger bit blocks
		wr(OFS_T3_MODE, 8'h10);
		wr(OFS_T4_MODE, 8'h10);
		settle();
		rd("status", OFS_PIN_STATUS, 8'h0f);
		chk("t3 in gate", 8'h03, 8'({t3_in, t3_gate}));
		chk("t4 in gate", 8'h03, 8'({t4_in, t4_gate}));
		chk("t4 ud tp", 8'h02, 8'({t4_ud, t4_tp}));
		for (int k = 4; k < 8; k++) begin
			wr(OFS_TRIG_SEL, 8'(1 << k));
			settle();
			chk("trigger", 8'h00, k < 6 ? 8'({t3_in, t3_gate}) : 8'({t4_in, t4_gate}));
		end
		wr(OFS_TRIG_SEL, 8'h00);
		wr(OFS_UPDOWN, 8'h80);
		settle();
		chk("t4 ud tp", 8'h01, 8'({t4_ud, t4_tp}));
		// pulse output, refused while two-phase is selected
		t4_pulse <= 1'b1;
		wr(OFS_PU_P8, 8'h01);
		wr(OFS_T4_MODE, 8'h04);
		settle();
		chk("pulse off", 8'h00, 8'(pin_oe_o[0]));
		wr(OFS_UPDOWN, 8'h00);
		settle();
		chk("pulse", 8'h03, 8'({pin_oe_o[0], pin_o[0]}));
		// three phase overrides bits 0 and 1
		ph_u <= 1'b1;
		wr(OFS_THREE_PHASE, 8'h04);
		settle();
		chk("phase", 8'h0d, 8'({pin_oe_o[1:0], pin_o[1:0]}));
		chk("t4 in", 8'h00, 8'(t4_in));
		wr(OFS_THREE_PHASE, 8'h00);
		wr(OFS_T4_MODE, 8'h00);
		// interrupt zero: pin edges count, register writes do not
		settle();
		n0 = reqs;
		ext_val <= 4'hb;
		settle();
		ext_val <= 4'hf;
		settle();
		chk("irq edges", 8'h02, 8'(reqs - n0));
		n0 = reqs;
		wr(OFS_PU_P8, 8'h00);
		wr(OFS_P8_DIR, 8'h02);
		settle();
		chk("irq writes", 8'h00, 8'(reqs - n0));
		conclude();
	end
endmodule
